// ===== shared/drp_pkg.sv
package drp_pkg;
	localparam int NCH        = 6;
	localparam int CNT_W      = 24;
	localparam int CMD_W      = 6;
	localparam int FIFO_DEPTH = 16;
	// request_select codes
	localparam logic [3:0] RS_EXT_DUAL = 4'h0;
	localparam logic [3:0] RS_EXT_M2D  = 4'h2;
	localparam logic [3:0] RS_EXT_D2M  = 4'h3;
	localparam logic [3:0] RS_AUTO     = 4'h4;
	localparam logic [3:0] RS_MODULE   = 4'h8;
	// module and register selectors
	localparam logic [5:0] MID_UART0 = 6'h08;
	localparam logic [5:0] MID_UART1 = 6'h0a;
	localparam logic [5:0] MID_SIO0  = 6'h14;
	localparam logic [5:0] MID_SIO1  = 6'h15;
	localparam logic [1:0] RID_TX    = 2'h1;
	localparam logic [1:0] RID_RX    = 2'h2;
	// {level_polarity, detect_kind}
	localparam logic [1:0] DET_LOW  = 2'h0;
	localparam logic [1:0] DET_FALL = 2'h1;
	localparam logic [1:0] DET_HIGH = 2'h2;
	localparam logic [1:0] DET_RISE = 2'h3;
	// {priority_mode_high, priority_mode_low}; 11 acts as fixed 1
	localparam logic [1:0] PRIO_FIX1 = 2'h0;
	localparam logic [1:0] PRIO_FIX2 = 2'h1;
	localparam logic [1:0] PRIO_RR   = 2'h2;
	// command word fields
	localparam int CMD_BURST  = 0;
	localparam int CMD_DIR    = 1;
	localparam int CMD_SINGLE = 2;
	localparam int CMD_CH_LSB = 3;
	// reset values
	localparam logic [2:0] RR_TOP_RST = 3'h0;
	localparam logic       SENSE_RST  = 1'b1;
endpackage

// ===== hw/drp_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module drp_fifo #(
	parameter int W     = 6,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         sys_rst_i,
	// fill side
	input  wire logic         in_valid_i,
	input  wire logic [W-1:0] in_data_i,
	output logic              in_ready_o,
	// drain side
	output logic              out_valid_o,
	output logic [W-1:0]      out_data_o,
	input  wire logic         out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
	logic [AW:0]   cnt_ff, nxt_cnt;
	logic          ov_ff, nxt_ov, we, push, fill;
	logic [W-1:0]  od_ff, nxt_od;

	function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// full is counted on storage only; the output register is extra slack
	assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid_o = ov_ff;
	assign out_data_o  = od_ff;

	always_comb begin
		push   = in_valid_i & in_ready_o;
		fill   = ~ov_ff | out_ready_i;
		nxt_wp = wp_ff;
		nxt_rp = rp_ff;
		nxt_od = od_ff;
		nxt_ov = ov_ff & ~out_ready_i;
		we     = 1'b0;
		if (fill && cnt_ff != '0) begin
			nxt_od = mem[rp_ff];
			nxt_rp = inc(rp_ff);
			nxt_ov = 1'b1;
			we     = push;
		end else if (fill && push) begin
			nxt_od = in_data_i;
			nxt_ov = 1'b1;
		end else begin
			we     = push;
		end
		if (we) begin
			nxt_wp = inc(wp_ff);
		end
		nxt_cnt = cnt_ff + (AW+1)'(we) - (AW+1)'(fill && cnt_ff != '0);
	end

	always_ff @(posedge core_clk_i) begin
		if (we) begin
			mem[wp_ff] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
			ov_ff  <= 1'b0;
			od_ff  <= '0;
		end else begin
			wp_ff  <= nxt_wp;
			rp_ff  <= nxt_rp;
			cnt_ff <= nxt_cnt;
			ov_ff  <= nxt_ov;
			od_ff  <= nxt_od;
		end
	end

	a_fifo_no_overflow: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		cnt_ff <= (AW+1)'(DEPTH)) else $error("fifo count past depth");
	a_fifo_stall_held: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ov_ff && !out_ready_i |=> ov_ff && $stable(od_ff)) else $error("fifo output lost");
endmodule
`default_nettype wire

// ===== hw/drp_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
module drp_arbiter (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       sys_rst_i,
	// requests and scheme
	input  wire logic [5:0] req_i,
	input  wire logic [1:0] prio_mode_i,
	// unit finished
	input  wire logic       done_i,
	input  wire logic [2:0] done_ch_i,
	// grant
	output logic            gnt_valid_o,
	output logic [2:0]      gnt_ch_o
);
	logic [2:0] top_ff, nxt_top;

	function automatic logic [2:0] wrap6(input logic [3:0] s);
		return (s >= 4'd6) ? 3'(s - 4'd6) : s[2:0];
	endfunction

	// channel sitting at rank p of the active scheme
	function automatic logic [2:0] rank_ch(input logic [1:0] m, input logic [2:0] top,
	                                       input logic [2:0] p);
		logic [2:0] f2 [6];
		f2 = '{3'd0, 3'd2, 3'd3, 3'd1, 3'd4, 3'd5};
		if (m == drp_pkg::PRIO_FIX2) begin
			return f2[p];
		end else if (m == drp_pkg::PRIO_RR) begin
			return wrap6({1'b0, top} + {1'b0, p});
		end
		return p;
	endfunction

	always_comb begin
		logic [2:0] c;
		c           = '0;
		gnt_valid_o = 1'b0;
		gnt_ch_o    = '0;
		for (int p = 5; p >= 0; p--) begin
			c = rank_ch(prio_mode_i, top_ff, 3'(p));
			if (req_i[c]) begin
				gnt_valid_o = 1'b1;
				gnt_ch_o    = c;
			end
		end
	end

	always_comb begin
		nxt_top = top_ff;
		if (done_i && prio_mode_i == drp_pkg::PRIO_RR) begin
			nxt_top = wrap6({1'b0, done_ch_i} + 4'd1);
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			top_ff <= drp_pkg::RR_TOP_RST;
		end else begin
			top_ff <= nxt_top;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_grant_has_req: assert property (gnt_valid_o |-> req_i[gnt_ch_o])
		else $error("grant to idle channel");
	a_fix1_ch0_wins: assert property (prio_mode_i == 2'h0 && req_i[0] |-> gnt_ch_o == 3'd0)
		else $error("fixed 1 order broken");
	a_fix2_ch2_over1: assert property (prio_mode_i == 2'h1 && req_i[2] && !req_i[0]
		|-> gnt_ch_o == 3'd2) else $error("fixed 2 order broken");
	a_rr_done_last: assert property (prio_mode_i == 2'h2 && done_i ##1
		prio_mode_i == 2'h2 && gnt_valid_o && gnt_ch_o == $past(done_ch_i)
		|-> req_i == 6'(6'h01 << gnt_ch_o)) else $error("finished channel not lowest");
endmodule
`default_nettype wire

// ===== hw/drp_dma_request.sv
`timescale 1ns/10ps
`default_nettype none
module drp_dma_request (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	// enables and abort flags
	input  wire logic [5:0]  channel_enable_i,
	input  wire logic        master_enable_i,
	input  wire logic        address_error_flag_i,
	input  wire logic        nmi_abort_flag_i,
	// per-channel configuration and priority scheme
	input  wire logic [23:0] request_select_i,
	input  wire logic [35:0] module_selector_i,
	input  wire logic [11:0] register_selector_i,
	input  wire logic [5:0]  bus_mode_burst_i,
	input  wire logic [5:0]  completion_irq_on_i,
	input  wire logic [1:0]  level_polarity_i,
	input  wire logic [1:0]  detect_kind_i,
	input  wire logic [1:0]  overrun_select_i,
	input  wire logic        priority_mode_low_i,
	input  wire logic        priority_mode_high_i,
	// transfer counter load and end flag clear
	input  wire logic [5:0]  count_load_i,
	input  wire logic [23:0] count_value_i,
	input  wire logic [5:0]  transfer_end_clear_i,
	// external request pins
	input  wire logic        ext_request_0_i,
	input  wire logic        ext_request_1_i,
	output logic [1:0]       ext_acknowledge_o,
	// on-chip module requests: uart0, uart1, sio0, sio1
	input  wire logic [3:0]  tx_empty_request_i,
	input  wire logic [3:0]  rx_full_request_i,
	// unit commands to the bus engine
	output logic             cmd_valid_o,
	output logic [5:0]       cmd_data_o,
	input  wire logic        cmd_ready_i,
	// unit completion from the bus engine
	input  wire logic        unit_done_i,
	input  wire logic [2:0]  unit_ch_i,
	// status
	output logic [5:0]       transfer_end_flag_o,
	output logic [5:0]       channel_busy_o,
	output logic             end_of_transfer_irq_o
);
	localparam int NCH = drp_pkg::NCH;
	localparam int CW  = drp_pkg::CNT_W;

	// ==========================================================
	// request decode
	logic [NCH-1:0] en, req, src, legal, single, dir, burst;
	logic [1:0]     pin, ext_pend, edge_seen;
	logic [3:0]     rs [NCH];
	logic           take;
	logic [2:0]     gnt_ch;
	logic           gnt_v;
	logic           fifo_ready;
	logic [5:0]     cmd_word;

	// ==========================================================
	// state
	logic [NCH-1:0]         busy_ff, nxt_busy;
	logic [NCH-1:0]         te_ff, nxt_te;
	logic [NCH-1:0][CW-1:0] cnt_ff, nxt_cnt;
	logic [1:0]             ack_ff, nxt_ack;
	logic [1:0]             sense_ff, nxt_sense;
	logic [1:0]             hold_ff, nxt_hold;
	logic [1:0]             edge_ff, nxt_edge;
	logic [1:0]             prev_ff, nxt_prev;
	logic                   irq_ff, nxt_irq;

	// returns {selector legal, request level}
	function automatic logic [1:0] mod_req(input logic [5:0] mid, input logic [1:0] register_selector,
	                                       input logic [3:0] tx, input logic [3:0] rx);
		logic [1:0] idx;
		logic       ok;
		idx = 2'd0;
		ok  = 1'b1;
		case (mid)
			drp_pkg::MID_UART0: idx = 2'd0;
			drp_pkg::MID_UART1: idx = 2'd1;
			drp_pkg::MID_SIO0:  idx = 2'd2;
			drp_pkg::MID_SIO1:  idx = 2'd3;
			default:            ok  = 1'b0;
		endcase
		if (register_selector == drp_pkg::RID_TX) begin
			return {ok, ok & tx[idx]};
		end else if (register_selector == drp_pkg::RID_RX) begin
			return {ok, ok & rx[idx]};
		end
		return 2'b00;
	endfunction

	assign pin = {ext_request_1_i, ext_request_0_i};

	// ==========================================================
	// external pin sensing, channels 0 and 1 only
	always_comb begin
		logic [1:0] det;
		logic       lvl;
		det       = '0;
		lvl       = 1'b0;
		ext_pend  = '0;
		edge_seen = '0;
		for (int c = 0; c < 2; c++) begin
			det = {level_polarity_i[c], detect_kind_i[c]};
			lvl = (det == drp_pkg::DET_HIGH) ? pin[c] : ~pin[c];
			edge_seen[c] = (det == drp_pkg::DET_RISE) ? (~prev_ff[c] & pin[c])
			                                          : (prev_ff[c] & ~pin[c]);
			// blind until acknowledge; in level mode overrun 0 adds one blind cycle
			ext_pend[c] = sense_ff[c] & (det[0] ? edge_ff[c] : (lvl & ~hold_ff[c]));
		end
	end

	always_comb begin
		logic [1:0] m;
		m      = '0;
		en     = '0;
		src    = '0;
		legal  = '0;
		single = '0;
		dir    = '0;
		burst  = '0;
		req    = '0;
		for (int c = 0; c < NCH; c++) begin
			rs[c] = request_select_i[4*c +: 4];
			en[c] = channel_enable_i[c] & master_enable_i & ~te_ff[c]
			      & ~address_error_flag_i & ~nmi_abort_flag_i;
			m = mod_req(module_selector_i[6*c +: 6], register_selector_i[2*c +: 2],
			            tx_empty_request_i, rx_full_request_i);
			burst[c] = bus_mode_burst_i[c];
			// the request source also sets single address, direction, and no burst for modules
			case (rs[c])
				drp_pkg::RS_AUTO: begin
					legal[c] = 1'b1;
					src[c]   = 1'b1;
				end
				// pin modes exist on channels 0 and 1 only
				drp_pkg::RS_EXT_DUAL, drp_pkg::RS_EXT_M2D, drp_pkg::RS_EXT_D2M: begin
					legal[c] = (c < 2);
					src[c]   = (c < 2) ? ext_pend[c[0]] : 1'b0;
					// single address only with the acknowledged device
					single[c] = (c < 2) && (rs[c] != drp_pkg::RS_EXT_DUAL);
					dir[c]    = (rs[c] == drp_pkg::RS_EXT_D2M);
				end
				drp_pkg::RS_MODULE: begin
					legal[c] = m[1];
					src[c]   = m[0];
					burst[c] = 1'b0;
				end
				default: begin
					legal[c] = 1'b0;
				end
			endcase
			// zero count means nothing left to move
			req[c] = en[c] & legal[c] & src[c] & ~busy_ff[c] & (cnt_ff[c] != '0);
		end
	end

	// ==========================================================
	// arbitration and command issue
	drp_arbiter u_arb (
		.core_clk_i  (core_clk_i),
		.sys_rst_i   (sys_rst_i),
		.req_i       (req),
		.prio_mode_i ({priority_mode_high_i, priority_mode_low_i}),
		.done_i      (unit_done_i),
		.done_ch_i   (unit_ch_i),
		.gnt_valid_o (gnt_v),
		.gnt_ch_o    (gnt_ch)
	);

	// a full queue stalls grants, so no request is consumed without a slot
	assign take = gnt_v & fifo_ready;

	always_comb begin
		cmd_word = '0;
		cmd_word[drp_pkg::CMD_CH_LSB +: 3] = gnt_ch;
		cmd_word[drp_pkg::CMD_SINGLE]      = single[gnt_ch];
		cmd_word[drp_pkg::CMD_DIR]         = dir[gnt_ch];
		cmd_word[drp_pkg::CMD_BURST]       = burst[gnt_ch];
	end

	drp_fifo #(
		.W     (drp_pkg::CMD_W),
		.DEPTH (drp_pkg::FIFO_DEPTH)
	) u_fifo (
		.core_clk_i  (core_clk_i),
		.sys_rst_i   (sys_rst_i),
		.in_valid_i  (gnt_v),
		.in_data_i   (cmd_word),
		.in_ready_o  (fifo_ready),
		.out_valid_o (cmd_valid_o),
		.out_data_o  (cmd_data_o),
		.out_ready_i (cmd_ready_i)
	);

	// ==========================================================
	// channel progress
	always_comb begin
		logic dn;
		dn       = 1'b0;
		nxt_busy = busy_ff;
		nxt_te   = te_ff;
		nxt_cnt  = cnt_ff;
		for (int c = 0; c < NCH; c++) begin
			dn = unit_done_i && (unit_ch_i == 3'(c));
			if (take && gnt_ch == 3'(c)) begin
				nxt_busy[c] = 1'b1;
			end else if (dn) begin
				nxt_busy[c] = 1'b0;
			end
			if (count_load_i[c]) begin
				nxt_cnt[c] = count_value_i;
			end else if (dn && cnt_ff[c] != '0) begin
				nxt_cnt[c] = cnt_ff[c] - 1'b1;
			end
			// set beats clear in the same cycle
			if (transfer_end_clear_i[c]) begin
				nxt_te[c] = 1'b0;
			end
			if (dn && cnt_ff[c] == CW'(1)) begin
				nxt_te[c] = 1'b1;
			end
		end
		nxt_irq = |(nxt_te & completion_irq_on_i);
	end

	// ==========================================================
	// pin handshake state
	always_comb begin
		logic tk;
		tk        = 1'b0;
		nxt_ack   = '0;
		nxt_sense = sense_ff;
		nxt_hold  = '0;
		nxt_edge  = edge_ff;
		nxt_prev  = pin;
		for (int c = 0; c < 2; c++) begin
			tk = take && gnt_ch == 3'(c) && rs[c] != drp_pkg::RS_AUTO
			     && rs[c] != drp_pkg::RS_MODULE;
			nxt_ack[c] = unit_done_i && unit_ch_i == 3'(c) && single[c] | (unit_done_i
			             && unit_ch_i == 3'(c) && rs[c] == drp_pkg::RS_EXT_DUAL);
			nxt_sense[c] = (sense_ff[c] | ack_ff[c]) & ~tk;
			// in level mode overrun 0 skips the first sample after acknowledge
			nxt_hold[c]  = ack_ff[c] & ~overrun_select_i[c];
			// latch in edge mode only: a polarity flip in level mode leaves no stale edge
			nxt_edge[c]  = (edge_ff[c] | (sense_ff[c] & detect_kind_i[c] & edge_seen[c]))
			               & ~tk;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			busy_ff  <= '0;
			te_ff    <= '0;
			cnt_ff   <= '0;
			irq_ff   <= 1'b0;
			ack_ff   <= '0;
			sense_ff <= {2{drp_pkg::SENSE_RST}};
			hold_ff  <= '0;
			edge_ff  <= '0;
			prev_ff  <= '0;
		end else begin
			busy_ff  <= nxt_busy;
			te_ff    <= nxt_te;
			cnt_ff   <= nxt_cnt;
			irq_ff   <= nxt_irq;
			ack_ff   <= nxt_ack;
			sense_ff <= nxt_sense;
			hold_ff  <= nxt_hold;
			edge_ff  <= nxt_edge;
			prev_ff  <= nxt_prev;
		end
	end

	assign ext_acknowledge_o     = ack_ff;
	assign transfer_end_flag_o   = te_ff;
	assign channel_busy_o        = busy_ff;
	assign end_of_transfer_irq_o = irq_ff;

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	a_te_on_last: assert property (unit_done_i && unit_ch_i == 3'd0 && cnt_ff[0] == 24'h1
		&& !count_load_i[0] |=> te_ff[0] ##1 te_ff[0] || $past(transfer_end_clear_i[0]))
		else $error("end flag not set on last unit");
	a_irq_follows_te: assert property (te_ff[1] && completion_irq_on_i[1]
		&& $stable(completion_irq_on_i) |-> end_of_transfer_irq_o)
		else $error("end interrupt missing");
	a_abort_no_take: assert property (address_error_flag_i || nmi_abort_flag_i
		|| !master_enable_i |-> !take) else $error("transfer started while aborted");
	a_module_no_burst: assert property (take && rs[gnt_ch] == 4'h8
		|-> !cmd_word[0]) else $error("module channel in burst");
	a_high_ch_no_pin: assert property (take && gnt_ch > 3'd1
		|-> rs[gnt_ch] == 4'h4 || rs[gnt_ch] == 4'h8) else $error("pin request on ch2-5");
	a_blind_till_ack: assert property (take && gnt_ch == 3'd0 && rs[0] == 4'h0
		|=> !sense_ff[0] throughout (!ack_ff[0])[*2]) else $error("pin sensed before ack");
	a_ack_after_done: assert property (unit_done_i && unit_ch_i == 3'd0 && rs[0] == 4'h2
		|=> ext_acknowledge_o[0] ##1 !ext_acknowledge_o[0] || unit_done_i)
		else $error("acknowledge not pulsed");
	a_reserved_idle: assert property (rs[4] != 4'h4 && rs[4] != 4'h8 |-> !req[4])
		else $error("reserved select requests");
endmodule
`default_nettype wire

// ===== testbench/drp_engine_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// bus engine stand-in
module drp_engine_model (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       sys_rst_i,
	// command side
	input  wire logic       cmd_valid_i,
	input  wire logic [5:0] cmd_data_i,
	input  wire logic       stall_i,
	output logic            cmd_ready_o,
	// completion side
	output logic            unit_done_o,
	output logic [2:0]      unit_ch_o
);
	logic       held_ff;
	logic [1:0] wait_ff;
	logic [2:0] ch_ff;
	assign cmd_ready_o = !held_ff && !stall_i;
	// channel field is junk outside the pulse
	assign unit_ch_o = unit_done_o ? ch_ff : ~ch_ff;
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			held_ff     <= 1'b0;
			wait_ff     <= 2'h0;
			ch_ff       <= 3'h0;
			unit_done_o <= 1'b0;
		end else begin
			unit_done_o <= held_ff && wait_ff == 2'h0;
			if (cmd_valid_i && cmd_ready_o) begin
				held_ff <= 1'b1;
				wait_ff <= 2'h2;
				ch_ff   <= cmd_data_i[5:3];
			end else if (held_ff && wait_ff == 2'h0) begin
				held_ff <= 1'b0;
			end else if (held_ff) begin
				wait_ff <= wait_ff - 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/dma_request_and_priority_bench.sv
`timescale 1ns/10ps
`default_nettype none
module dma_request_and_priority_bench;
	// ==========
	// signals
	logic        core_clk_i, sys_rst_i, master_enable_i, address_error_flag_i;
	logic        nmi_abort_flag_i, priority_mode_low_i, priority_mode_high_i;
	logic        cmd_ready_i, unit_done_i, cmd_valid_o, end_of_transfer_irq_o;
	logic        stall, req_on, ack_seen;
	logic [1:0]  level_polarity_i, detect_kind_i, overrun_select_i, ext_acknowledge_o;
	logic [2:0]  unit_ch_i;
	logic [3:0]  tx_empty_request_i, rx_full_request_i;
	logic [5:0]  channel_enable_i, bus_mode_burst_i, completion_irq_on_i, count_load_i;
	logic [5:0]  transfer_end_clear_i, transfer_end_flag_o, channel_busy_o, cmd_data_o;
	logic [11:0] register_selector_i;
	logic [23:0] request_select_i, count_value_i;
	logic [35:0] module_selector_i;
	wire logic   ext_request_0_i, ext_request_1_i;
	logic [5:0]  got_q[$];
	int          n_fail, checks_done, n_ack, c, n;
	logic [3:0]  resv [11] = '{4'h1, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
	logic [3:0]  rsx [3] = '{drp_pkg::RS_EXT_DUAL, drp_pkg::RS_EXT_M2D, drp_pkg::RS_EXT_D2M};
	logic [5:0]  mids [4] = '{drp_pkg::MID_UART0, drp_pkg::MID_UART1,
		drp_pkg::MID_SIO0, drp_pkg::MID_SIO1};
	// requester holds its pin active until acknowledged
	assign ext_request_0_i = req_on ~^ level_polarity_i[0];
	assign ext_request_1_i = ext_request_0_i;
	drp_dma_request u_drp_dma_request (
		.core_clk_i, .sys_rst_i, .channel_enable_i, .master_enable_i,
		.address_error_flag_i, .nmi_abort_flag_i, .request_select_i, .module_selector_i,
		.register_selector_i, .bus_mode_burst_i, .completion_irq_on_i, .level_polarity_i,
		.detect_kind_i, .overrun_select_i, .priority_mode_low_i, .priority_mode_high_i,
		.count_load_i, .count_value_i, .transfer_end_clear_i, .ext_request_0_i,
		.ext_request_1_i, .ext_acknowledge_o, .tx_empty_request_i, .rx_full_request_i,
		.cmd_valid_o, .cmd_data_o, .cmd_ready_i, .unit_done_i, .unit_ch_i,
		.transfer_end_flag_o, .channel_busy_o, .end_of_transfer_irq_o
	);
	drp_engine_model u_drp_engine_model (
		.core_clk_i, .sys_rst_i, .cmd_valid_i(cmd_valid_o), .cmd_data_i(cmd_data_o),
		.stall_i(stall), .cmd_ready_o(cmd_ready_i), .unit_done_o(unit_done_i),
		.unit_ch_o(unit_ch_i)
	);
	// ==========
	// checking helpers
	task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string s);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// requester lets go one cycle after it sees the acknowledge, so overrun 1 bites
	always @(posedge core_clk_i) begin
		if (cmd_valid_o && cmd_ready_i)
			got_q.push_back(cmd_data_o);
		ack_seen <= ext_acknowledge_o[0];
		if (ext_acknowledge_o[0])
			n_ack <= n_ack + 1;
		if (ack_seen)
			req_on <= 1'b0;
	end
	function automatic logic [2:0] rank(input logic [1:0] mode, input int st, input int i);
		int fix2 [6];
		fix2 = '{0, 2, 3, 1, 4, 5};
		if (mode == drp_pkg::PRIO_FIX2)
			return 3'(fix2[i]);
		if (mode == drp_pkg::PRIO_RR)
			return 3'((st + i) % 6);
		return 3'(i);
	endfunction
	// waits for eight idle cycles; gives up after 400
	task automatic drain();
		int quiet;
		quiet = 0;
		for (int i = 0; i < 400 && quiet < 8; i++) begin
			@(posedge core_clk_i);
			quiet = (channel_busy_o === 6'h00 && cmd_valid_o === 1'b0) ? quiet + 1 : 0;
		end
		if (quiet < 8) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	task automatic load(input int ch, input logic [3:0] rs, input logic [23:0] cnt);
		@(posedge core_clk_i);
		request_select_i[4*ch +: 4] <= rs;
		count_value_i <= cnt;
		count_load_i <= 6'h01 << ch;
		@(posedge core_clk_i);
		count_load_i <= 6'h00;
	endtask
	task automatic clear_all();
		@(posedge core_clk_i);
		{channel_enable_i, bus_mode_burst_i, transfer_end_clear_i} <= {12'h0, 6'h3f};
		{tx_empty_request_i, rx_full_request_i} <= 8'h0;
		@(posedge core_clk_i);
		transfer_end_clear_i <= 6'h00;
		repeat (2) @(posedge core_clk_i);
		check_val({1'b0, end_of_transfer_irq_o, transfer_end_flag_o}, 8'h0, "clear");
		got_q.delete();
	endtask
	// ==========
	// scenarios
	task automatic prio_run(input logic [1:0] mode, input int st);
		@(posedge core_clk_i);
		{priority_mode_high_i, priority_mode_low_i} <= mode;
		stall <= 1'b1;
		completion_irq_on_i <= 6'($urandom());
		for (int k = 0; k < 6; k++)
			load(k, drp_pkg::RS_AUTO, 24'h1);
		@(posedge core_clk_i);
		channel_enable_i <= 6'h3f;
		repeat (12) @(posedge core_clk_i);
		// commands queue inside and stand while the engine stalls
		check_val(8'(got_q.size()), 8'h0, "stalled");
		check_val(8'(channel_busy_o), 8'h3f, "queued");
		check_val(8'(cmd_valid_o), 8'h1, "held");
		check_val(8'(cmd_data_o[5:3]), 8'(rank(mode, st, 0)), "head");
		stall <= 1'b0;
		drain();
		check_val(8'(cmd_valid_o), 8'h0, "empty");
		check_val(8'(got_q.size()), 8'h6, "grants");
		foreach (got_q[i])
			check_val(8'(got_q[i][5:3]), 8'(rank(mode, st, i)), "order");
		check_val(8'(transfer_end_flag_o), 8'h3f, "ends");
		check_val(8'(end_of_transfer_irq_o), 8'(|completion_irq_on_i), "irq");
		clear_all();
	endtask
	task automatic ext_run(input logic [1:0] det, input logic ov, input logic [3:0] rs);
		int e;
		e = (det[0] || !ov) ? 1 : 2;
		@(posedge core_clk_i);
		{level_polarity_i[0], detect_kind_i[0]} <= det;
		overrun_select_i[0] <= ov;
		n_ack = 0;
		load(0, rs, 24'h8);
		load(2, drp_pkg::RS_EXT_DUAL, 24'h8);
		@(posedge core_clk_i);
		channel_enable_i <= 6'h05;
		repeat (4) @(posedge core_clk_i);
		req_on <= 1'b1;
		drain();
		check_val(8'(got_q.size()), 8'(e), "pin units");
		check_val(8'(n_ack), 8'(e), "acks");
		foreach (got_q[i])
			check_val(8'(got_q[i]), {5'h0, rs[1], rs[0], 1'b0}, "pin cmd");
		clear_all();
	endtask
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	initial begin
		{sys_rst_i, master_enable_i, address_error_flag_i, nmi_abort_flag_i} = 4'hc;
		{priority_mode_low_i, priority_mode_high_i, stall, req_on, ack_seen} = '0;
		{level_polarity_i, detect_kind_i, overrun_select_i, tx_empty_request_i} = '0;
		{rx_full_request_i, channel_enable_i, bus_mode_burst_i, completion_irq_on_i} = '0;
		{count_load_i, transfer_end_clear_i, register_selector_i, request_select_i} = '0;
		{count_value_i, module_selector_i} = '0;
		{n_fail, checks_done, n_ack} = '0;
		void'($urandom(490));
		repeat (16) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge core_clk_i);
		channel_enable_i <= 6'h3f;
		request_select_i <= {6{drp_pkg::RS_AUTO}};
		repeat (8) @(posedge core_clk_i);
		// unloaded counters never request
		check_val(8'(got_q.size()), 8'h0, "idle");
		clear_all();
		prio_run(drp_pkg::PRIO_RR, 0);
		// a lone channel 2 moves rotation to start at 3
		n = $urandom_range(4, 1);
		load(2, drp_pkg::RS_AUTO, 24'(n));
		@(posedge core_clk_i);
		channel_enable_i <= 6'h04;
		drain();
		check_val(8'(got_q.size()), 8'(n), "units");
		check_val(8'(transfer_end_flag_o), 8'h04, "end");
		check_val(8'(end_of_transfer_irq_o), 8'(completion_irq_on_i[2]), "irq");
		clear_all();
		prio_run(drp_pkg::PRIO_RR, 3);
		prio_run(drp_pkg::PRIO_FIX1, 0);
		prio_run(drp_pkg::PRIO_FIX2, 0);
		prio_run(2'h3, 0);
		for (int k = 0; k < 4; k++) begin
			load(4, k == 0 ? resv[$urandom_range(10, 0)] : drp_pkg::RS_AUTO, 24'h1);
			@(posedge core_clk_i);
			{address_error_flag_i, nmi_abort_flag_i, master_enable_i} <= {k == 1, k == 2, k != 3};
			channel_enable_i <= 6'h10;
			repeat (10) @(posedge core_clk_i);
			check_val(8'(got_q.size()), 8'h0, "blocked");
			{address_error_flag_i, nmi_abort_flag_i, master_enable_i} <= 3'b001;
			drain();
			check_val(8'(got_q.size()), 8'(k != 0), "released");
			clear_all();
		end
		// data registers and rx draining stay with software; only routing here
		for (int i = 0; i < 8; i++) begin
			c = $urandom_range(5, 0);
			@(posedge core_clk_i);
			module_selector_i[6*c +: 6] <= mids[i/2];
			register_selector_i[2*c +: 2] <= i[0] ? drp_pkg::RID_RX : drp_pkg::RID_TX;
			bus_mode_burst_i <= 6'h3f;
			tx_empty_request_i <= i[0] ? 4'hf : ~(4'h1 << i/2);
			rx_full_request_i <= i[0] ? ~(4'h1 << i/2) : 4'hf;
			load(c, drp_pkg::RS_MODULE, 24'h1);
			@(posedge core_clk_i);
			channel_enable_i <= 6'h01 << c;
			repeat (10) @(posedge core_clk_i);
			check_val(8'(got_q.size()), 8'h0, "wrong source");
			{tx_empty_request_i, rx_full_request_i} <= 8'hff;
			drain();
			check_val(8'(got_q.size()), 8'h1, "module unit");
			check_val(8'({got_q[0][5:3], got_q[0][0]}), 8'({c[2:0], 1'b0}), "steal");
			clear_all();
		end
		for (int i = 0; i < 8; i++)
			ext_run(i[1:0], i[2], rsx[i % 3]);
		tally_and_finish();
	end
endmodule
`default_nettype wire
